// File: qdsw_defines.vh
// Purpose: shared constants of the quad converter serial write port
// Assumes: included by bare name from the design files
// Notes: frame field layout below is a local decision
`ifndef QDSW_DEFINES_VH
`define QDSW_DEFINES_VH

`define QDSW_WORD_BITS 24
`define QDSW_CNT_BITS 5
// bit counter value while the 24th serial clock fall is taken
`define QDSW_LAST_CNT 5'h17
`define QDSW_CNT_ONE 5'h01
`define QDSW_CHANNELS 4
`define QDSW_CODE_BITS 16
`define QDSW_SYNC_STAGES 3
// frame fields, msb first on the wire
`define QDSW_ADDR_HI 23
`define QDSW_ADDR_LO 22
`define QDSW_UPDATE_BIT 20
`define QDSW_CHAN_HI 17
`define QDSW_CHAN_LO 16
`define QDSW_CODE_HI 15
`define QDSW_CODE_LO 0
`define QDSW_CODE_RESET 16'h0000

`endif

// File: qdsw_chan_regs.v
// Purpose: pending and active code registers for the four channels
// Assumes: one write request per cycle from the serial port, possibly in the same cycle as a load request
// Notes: active codes come straight out of flip-flops
`default_nettype none
`include "qdsw_defines.vh"

module qdsw_chan_regs #(
    parameter CHANNELS = `QDSW_CHANNELS,
    parameter CODE_BITS = `QDSW_CODE_BITS
) (
    input wire i_sys_clk,
    input wire i_rst,
    input wire i_wr_en,
    input wire [1:0] i_wr_chan,
    input wire [CODE_BITS-1:0] i_wr_code,
    input wire i_wr_update,
    input wire i_load_all,
    output wire [CHANNELS*CODE_BITS-1:0] o_codes
);
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch = ch + 1)
        begin : g_chan
            reg [CODE_BITS-1:0] pending_reg;
            reg [CODE_BITS-1:0] active_reg;
            wire hit;
            assign hit = i_wr_en && ({{30{1'b0}}, i_wr_chan} == ch);
            always @(posedge i_sys_clk or posedge i_rst)
            begin
                if (i_rst)
                begin
                    pending_reg <= `QDSW_CODE_RESET;
                    active_reg <= `QDSW_CODE_RESET;
                end
                else
                begin
                    if (hit)
                        pending_reg <= i_wr_code;
                    // a same-cycle write with update goes straight through
                    if (hit && i_wr_update)
                        active_reg <= i_wr_code;
                    else if (i_load_all)
                        active_reg <= pending_reg; // [R7]
                end
            end
            assign o_codes[ch*CODE_BITS +: CODE_BITS] = active_reg;
        end
    endgenerate
endmodule
`default_nettype wire

// File: qdsw_serial_port.v
// Purpose: serial write port of a four-channel voltage-output converter
// Assumes: pins are asynchronous to i_sys_clk; serial clock far slower than it
// Notes: every pin passes three flops; a change counts when stages two and three agree
// How it works
// [R1] controller opens each frame with sync low
// [R2] sync low: sample data on serial clock falls
// [R3] shift register is 24 bits, one per edge
// [R4] 24th edge completes frame; the channel code goes live only when the update bit is set
// [R5] early sync rise aborts, nothing changes
// [R6] port listens only while enable is low
// [R7] load strobe rising edge loads all channels
// [R8] act only on frames matching strapped address
// [R9] enable high: ignore frame pins, keep registers; a load strobe rise still loads all channels
`default_nettype none
`include "qdsw_defines.vh"

module qdsw_serial_port #(
    parameter WORD_BITS = `QDSW_WORD_BITS,
    parameter CHANNELS = `QDSW_CHANNELS,
    parameter CODE_BITS = `QDSW_CODE_BITS
) (
    input wire i_sys_clk,
    input wire i_rst,
    input wire i_frame_sync_n,
    input wire i_serial_clk,
    input wire i_serial_data,
    input wire i_port_enable_n,
    input wire i_address_strap_low,
    input wire i_address_strap_high,
    input wire i_load_all_channels_strobe,
    output wire [CHANNELS*CODE_BITS-1:0] o_channel_codes,
    output reg o_frame_done,
    output reg o_frame_abort,
    output reg o_frame_busy
);
    localparam NPIN = 7;
    localparam P_SYNC = 0;
    localparam P_SCLK = 1;
    localparam P_DATA = 2;
    localparam P_EN = 3;
    localparam P_A0 = 4;
    localparam P_A1 = 5;
    localparam P_LOAD = 6;
    localparam ST_IDLE = 2'h0;
    localparam ST_SHIFT = 2'h1;
    localparam ST_WAIT = 2'h2;
    // counter still shows 23 while the 24th fall is being taken
    localparam [`QDSW_CNT_BITS-1:0] LAST = `QDSW_LAST_CNT;

    wire [NPIN-1:0] pin_raw;
    wire [NPIN-1:0] pin_lvl_reg;
    wire [NPIN-1:0] pin_lvl_next;
    wire [NPIN-1:0] pin_rise;
    wire [NPIN-1:0] pin_fall;
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [`QDSW_CNT_BITS-1:0] cnt_reg;
    reg [`QDSW_CNT_BITS-1:0] cnt_next;
    reg [WORD_BITS-1:0] shift_reg;
    reg [WORD_BITS-1:0] shift_next;
    reg [1:0] strap_reg;
    reg wr_en;
    reg done_next;
    reg abort_next;
    wire port_on;
    wire [WORD_BITS-1:0] word_full;

    assign pin_raw = {i_load_all_channels_strobe, i_address_strap_high, i_address_strap_low,
                      i_port_enable_n, i_serial_data, i_serial_clk, i_frame_sync_n};

    genvar p;
    generate
        for (p = 0; p < NPIN; p = p + 1)
        begin : g_pin
            reg s1_reg;
            reg s2_reg;
            reg s3_reg;
            reg lvl_reg;
            reg lvl_next;
            // sync and serial clock idle high, so the preset level gives no false fall after reset
            always @(posedge i_sys_clk or posedge i_rst)
            begin
                if (i_rst)
                begin
                    s1_reg <= 1'b1;
                    s2_reg <= 1'b1;
                    s3_reg <= 1'b1;
                    lvl_reg <= 1'b1;
                end
                else
                begin
                    s1_reg <= pin_raw[p];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                    lvl_reg <= lvl_next;
                end
            end
            // a change counts only once stages two and three agree
            always @*
            begin
                lvl_next = lvl_reg;
                if (s2_reg == s3_reg)
                    lvl_next = s3_reg;
            end
            assign pin_lvl_reg[p] = lvl_reg;
            assign pin_lvl_next[p] = lvl_next;
            assign pin_rise[p] = lvl_next && !lvl_reg;
            assign pin_fall[p] = !lvl_next && lvl_reg;
        end
    endgenerate

    assign port_on = !pin_lvl_reg[P_EN]; // [R6]
    assign word_full = {shift_reg[WORD_BITS-2:0], pin_lvl_next[P_DATA]};

    always @*
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        shift_next = shift_reg;
        wr_en = 1'b0;
        done_next = 1'b0;
        abort_next = 1'b0;
        case (state_reg)
            ST_IDLE:
            begin
                if (port_on && pin_fall[P_SYNC]) // [R1]
                begin
                    state_next = ST_SHIFT;
                    cnt_next = {`QDSW_CNT_BITS{1'b0}};
                end
            end
            ST_SHIFT:
            begin
                if (!port_on)
                    state_next = ST_IDLE; // [R9]
                else if (pin_rise[P_SYNC])
                begin
                    state_next = ST_IDLE; // [R5]
                    abort_next = 1'b1;
                end
                else if (pin_fall[P_SCLK])
                begin
                    shift_next = word_full; // [R2] [R3]
                    cnt_next = cnt_reg + `QDSW_CNT_ONE;
                    if (cnt_reg == LAST)
                    begin
                        state_next = ST_WAIT;
                        done_next = 1'b1; // [R4]
                        wr_en = (word_full[`QDSW_ADDR_HI:`QDSW_ADDR_LO] == strap_reg); // [R8]
                    end
                end
            end
            ST_WAIT:
            begin
                if (pin_rise[P_SYNC] || !port_on)
                    state_next = ST_IDLE;
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_reg <= ST_IDLE;
            cnt_reg <= {`QDSW_CNT_BITS{1'b0}};
            shift_reg <= {WORD_BITS{1'b0}};
            strap_reg <= 2'b00;
            o_frame_done <= 1'b0;
            o_frame_abort <= 1'b0;
            o_frame_busy <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            shift_reg <= shift_next;
            strap_reg <= {pin_lvl_reg[P_A1], pin_lvl_reg[P_A0]}; // [R8]
            o_frame_done <= done_next;
            o_frame_abort <= abort_next;
            o_frame_busy <= (state_next == ST_SHIFT);
        end
    end

    qdsw_chan_regs #(
        .CHANNELS(CHANNELS),
        .CODE_BITS(CODE_BITS)
    ) u_chan_regs (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_wr_en(wr_en),
        .i_wr_chan(word_full[`QDSW_CHAN_HI:`QDSW_CHAN_LO]),
        .i_wr_code(word_full[`QDSW_CODE_HI:`QDSW_CODE_LO]),
        .i_wr_update(word_full[`QDSW_UPDATE_BIT]),
        .i_load_all(pin_rise[P_LOAD]), // [R7]
        .o_codes(o_channel_codes)
    );
endmodule
`default_nettype wire

// File: qdsw_chk.sv
// Purpose: pin-level checks of the serial write port
// Assumes: outputs settle on the rising clock
// Notes: load and write latencies as handed over
`default_nettype none
module qdsw_chk (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_port_enable_n,
    input wire logic i_load_all_channels_strobe,
    input wire logic [63:0] o_channel_codes,
    input wire logic o_frame_done,
    input wire logic o_frame_abort,
    input wire logic o_frame_busy
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    done_idle_a: assert property (o_frame_done |-> !o_frame_busy)
        else $error("done while busy");
    abort_idle_a: assert property (o_frame_abort |-> !o_frame_busy)
        else $error("abort while busy");
    done_pulse_a: assert property (o_frame_done |=> !o_frame_done)
        else $error("done too long");
    no_clash_a: assert property (!(o_frame_done && o_frame_abort))
        else $error("done with abort");
    done_after_a: assert property (o_frame_done |-> $past(o_frame_busy))
        else $error("done without frame");
    abort_after_a: assert property ($rose(o_frame_abort) |-> $past(o_frame_busy))
        else $error("abort without frame");
    codes_hold_a: assert property (!$stable(o_channel_codes) |->
        o_frame_done || $past(i_load_all_channels_strobe, 3)) else $error("codes moved alone");
    disabled_quiet_a: assert property (i_port_enable_n [*8] |-> !o_frame_busy && !o_frame_done)
        else $error("active while disabled");
endmodule
bind qdsw_serial_port qdsw_chk i_qdsw_chk (.i_sys_clk, .i_rst, .i_port_enable_n, .i_load_all_channels_strobe,
    .o_channel_codes, .o_frame_done, .o_frame_abort, .o_frame_busy);
`default_nettype wire

// File: qdsw_host.sv
// Purpose: host controller sending frames
// Assumes: serial clock period 125 ns
// Notes: clock idles high between frames
`default_nettype none
module qdsw_host (
    input wire logic i_sys_clk,
    output logic o_sync_n,
    output logic o_sclk,
    output logic o_sdata
);
    timeunit 1ns;
    timeprecision 100ps;
    initial {o_sync_n, o_sclk, o_sdata} = 3'h7;
    task automatic send(input logic [23:0] w, input int n);
        @(negedge i_sys_clk);
        o_sync_n = 1'b0;
        for (int i = 23; i > 23 - n; i--)
        begin
            o_sdata = w[i];
            #62.5 o_sclk = 1'b0;
            #62.5 o_sclk = 1'b1;
        end
        // released data line shows no stale bit
        o_sdata = ~o_sdata;
        #62.5 o_sync_n = 1'b1;
    endtask
endmodule
`default_nettype wire

// File: qdsw_serial_port_tb.sv
// Purpose: self-checking bench of the serial write port
// Assumes: straps give address 2
// Notes: a monitor counts done and abort pulses
`default_nettype none
module qdsw_serial_port_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, rst = 1, en_n = 0, ld = 0;
    wire sync_n, sclk, sdata, done, abort, busy;
    wire [63:0] codes;
    logic [63:0] exp = 64'h0;
    int error_cnt = 0, num_checks = 0, n_done = 0, n_abort = 0, n_busy = 0;
    logic busy_d = 0;
    qdsw_serial_port i_qdsw_serial_port (.i_sys_clk(clk), .i_rst(rst), .i_frame_sync_n(sync_n),
        .i_serial_clk(sclk), .i_serial_data(sdata), .i_port_enable_n(en_n), .i_address_strap_low(1'b0),
        .i_address_strap_high(1'b1), .i_load_all_channels_strobe(ld), .o_channel_codes(codes),
        .o_frame_done(done), .o_frame_abort(abort), .o_frame_busy(busy));
    qdsw_host i_qdsw_host (.i_sys_clk(clk), .o_sync_n(sync_n), .o_sclk(sclk), .o_sdata(sdata));
    initial forever #2 clk = ~clk;
    always @(negedge clk)
    begin
        n_done += (done === 1'b1);
        n_abort += (abort === 1'b1);
        n_busy += (busy === 1'b1 && busy_d !== 1'b1);
        busy_d = busy;
    end
    task automatic chk(input string name, input logic [63:0] seen, want);
        num_checks++;
        if (seen !== want)
        begin
            error_cnt++;
            $display("Error %s exp %h seen %h", name, want, seen);
        end
    endtask
    task automatic run(input logic [23:0] w, input int n, input int dn, input int ab);
        int d0 = n_done;
        int a0 = n_abort;
        int b0 = n_busy;
        i_qdsw_host.send(w, n);
        repeat (12) @(negedge clk);
        chk("done", 64'(n_done - d0), 64'(dn));
        chk("abort", 64'(n_abort - a0), 64'(ab));
        chk("busy", 64'(n_busy - b0), 64'(dn + ab));
        chk("codes", codes, exp);
    endtask
    task t_write;
        exp[47:32] = 16'hA5C3;
        run(24'h92A5C3, 24, 1, 0);
    endtask
    task t_other_addr;
        run(24'h515A5A, 24, 1, 0);
    endtask
    task t_abort;
        run(24'h907777, 23, 0, 1);
    endtask
    task t_load;
        run(24'h801234, 24, 1, 0);
        ld = 1'b1;
        exp[15:0] = 16'h1234;
        run(24'h811111, 24, 1, 0);
        ld = 1'b0;
        repeat (8) @(negedge clk);
        ld = 1'b1;
        exp[31:16] = 16'h1111;
        repeat (8) @(negedge clk);
        chk("load", codes, exp);
        ld = 1'b0;
    endtask
    task t_reset;
        rst = 1'b1;
        exp = 64'h0;
        repeat (3) @(negedge clk);
        chk("reset codes", codes, exp);
        chk("reset busy", 64'(busy), 64'h0);
        rst = 1'b0;
        repeat (10) @(negedge clk);
        exp[15:0] = 16'h4321;
        run(24'h904321, 24, 1, 0);
    endtask
    task t_disabled;
        en_n = 1'b1;
        repeat (4) @(negedge clk);
        run(24'h93BEEF, 24, 0, 0);
        en_n = 1'b0;
        repeat (8) @(negedge clk);
        exp[63:48] = 16'hBEEF;
        run(24'h93BEEF, 24, 1, 0);
    endtask
    task conclude;
        if (error_cnt == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        #100000;
        error_cnt++;
        conclude();
    end
    initial
    begin
        repeat (3) @(negedge clk);
        rst = 1'b0;
        repeat (10) @(negedge clk);
        t_write();
        t_other_addr();
        t_abort();
        t_load();
        t_disabled();
        t_reset();
        conclude();
    end
endmodule
`default_nettype wire
